/* File: mcuifd_pkg.sv */
// constants, types and carriers for the instruction format decoder
package mcuifd_pkg;

    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;

    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [7:0] SFR_BASE = 8'h80;
    localparam logic [3:0] XMOVE_BASE_CYCLES = 4'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // flag mask bit positions
    localparam int FLAG_P = 3;
    localparam int FLAG_OV = 2;
    localparam int FLAG_AC = 1;
    localparam int FLAG_CY = 0;

    typedef enum logic [1:0] {
        FETCH_OP = 2'b00,
        FETCH_B1 = 2'b01,
        FETCH_B2 = 2'b10,
        EXEC_WAIT = 2'b11
    } mcuifd_state_t;

    typedef enum logic [1:0] {
        OPND_NONE = 2'b00,
        OPND_REG = 2'b01,
        OPND_IND = 2'b10
    } mcuifd_opnd_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] opnd1;
        logic [7:0] opnd2;
        logic [1:0] len;
    } mcuifd_insn_t;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] flags;
        mcuifd_opnd_t opnd;
        logic has_direct;
        logic rel2;
        logic is_rel;
        logic abs11;
        logic abs16;
        logic movx;
    } mcuifd_class_t;

endpackage

/* File: mcuifd_opclass.sv */
// opcode classifier: length, operand form, flag effects
`timescale 1ns/1ps
module mcuifd_opclass (
    input wire logic [7:0] opcode, // opcode byte
    output mcuifd_pkg::mcuifd_class_t cls // decoded class
);
    logic [1:0] len;
    logic [3:0] flags;
    logic has_direct;

    // priority order matters: three-byte codes are matched before broad two-byte patterns
    always_comb begin
        casez (opcode)
            8'h02, 8'h12, 8'h10, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63,
            8'h75, 8'h85, 8'h90, 8'hB4, 8'hB5, 8'hD5, 8'b1011_011?, 8'b1011_1???:
                len = mcuifd_pkg::LEN_THREE;
            8'h?1, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'b0???0101, 8'h95,
            8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94,
            8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'hA0, 8'hA2, 8'hB0, 8'hB2,
            8'hC0, 8'hC2, 8'hD0, 8'hD2, 8'hC5, 8'hE5, 8'hF5,
            8'b1000_011?, 8'b1000_1???, 8'b0111_011?, 8'b0111_1???,
            8'b1010_011?, 8'b1010_1???, 8'b1101_1???:
                len = mcuifd_pkg::LEN_TWO;
            default:
                len = mcuifd_pkg::LEN_ONE;
        endcase
    end

    // flag mask order is P, OV, AC, CY
    always_comb begin
        casez (opcode)
            8'b001?01??, 8'b001?1???, 8'b1001_01??, 8'b1001_1???:
                flags = 4'b1111;
            8'hA4, 8'h84:
                flags = 4'b1101;
            8'hD4, 8'h33, 8'h13:
                flags = 4'b1001;
            8'h04, 8'h14, 8'hE4, 8'hF4, 8'h74, 8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hC5,
            8'b010?01??, 8'b010?1???, 8'b0110_01??, 8'b0110_1???,
            8'b1110_01??, 8'b1110_1???, 8'b1100_011?, 8'b1100_1???, 8'b1101_011?:
                flags = 4'b1000;
            8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2, 8'hB3, 8'hC3, 8'hD3:
                flags = 4'b0001;
            default:
                flags = 4'b0000;
        endcase
    end

    always_comb begin
        casez (opcode)
            8'b0???0101, 8'h95, 8'h42, 8'h43, 8'h52, 8'h53, 8'h62, 8'h63, 8'h85,
            8'b1000_011?, 8'b1000_1???, 8'b1010_011?, 8'b1010_1???,
            8'hC0, 8'hD0, 8'hC5, 8'hD5, 8'hE5, 8'hF5, 8'hB5:
                has_direct = 1'b1;
            default:
                has_direct = 1'b0;
        endcase
    end

    wire is_rn = opcode[3];
    wire is_ri = (opcode[3:1] == 3'b011) || (opcode[7:5] == 3'b111 && opcode[3:1] == 3'b001);
    wire rel_two = (opcode == 8'h40) || (opcode == 8'h50) || (opcode == 8'h60) || (opcode == 8'h70)
        || (opcode == 8'h80) || (opcode[7:3] == 5'b11011);
    wire rel_three = (opcode == 8'h10) || (opcode == 8'h20) || (opcode == 8'h30) || (opcode == 8'hD5)
        || (opcode[7:2] == 6'b101101) || (opcode[7:3] == 5'b10111);

    assign cls.len = len;
    assign cls.flags = flags;
    assign cls.opnd = is_rn ? mcuifd_pkg::OPND_REG
        : (is_ri ? mcuifd_pkg::OPND_IND : mcuifd_pkg::OPND_NONE);
    assign cls.has_direct = has_direct;
    assign cls.rel2 = rel_three;
    assign cls.is_rel = rel_two || rel_three;
    assign cls.abs11 = (opcode[3:0] == 4'h1);
    assign cls.abs16 = (opcode == 8'h02) || (opcode == 8'h12);
    assign cls.movx = (opcode[7:5] == 3'b111) && (opcode[3:0] == 4'h0 || opcode[3:1] == 3'b001);
endmodule

/* File: mcuifd_top.sv */
// instruction fetch sequencer and operand form decoder
`timescale 1ns/1ps
module mcuifd_top (
    input wire logic CLK, // core clock
    input wire logic RST_N, // synchronous reset, active low
    input wire logic [7:0] PM_DATA, // program memory byte at PM_ADDR
    input wire logic PM_VALID, // PM_DATA is valid this cycle
    input wire logic [1:0] BANK_SEL, // active register bank
    input wire logic [2:0] EXTERNAL_ACCESS_TIMING_CONTROL, // external move timing field
    input wire logic EXEC_DONE, // core finished the decoded instruction
    input wire logic EXEC_TAKE, // branch condition met
    input wire logic EXEC_LOAD, // load counter from EXEC_ADDR instead
    input wire logic [15:0] EXEC_ADDR, // computed target for indirect jumps and returns
    output logic [15:0] PM_ADDR, // program counter, fetch address
    output logic PM_RD, // fetch request
    output logic INSN_VALID, // one-cycle pulse, new instruction
    output mcuifd_pkg::mcuifd_insn_t INSN, // opcode, operands, length
    output mcuifd_pkg::mcuifd_opnd_t OPND_KIND, // register operand form
    output logic [4:0] REG_ADDR, // bank and working register
    output logic [7:0] DIRECT_ADDR, // direct operand address
    output logic DIRECT_SFR, // direct address is in register space
    output logic [15:0] BRANCH_TARGET, // target if branch applies
    output logic [3:0] FLAG_MASK, // flags touched: P, OV, AC, CY
    output logic [3:0] XMOVE_CYCLES // cycles of an external move, zero otherwise
);
    mcuifd_pkg::mcuifd_state_t state_reg, state_next;
    logic [7:0] op_reg;
    logic [7:0] b1_reg;
    mcuifd_pkg::mcuifd_class_t cls;

    ////////////////////////////////////////////////////////////////////////
    // decode of the byte stream

    wire take = PM_RD && PM_VALID;
    wire [7:0] op_now = (state_reg == mcuifd_pkg::FETCH_OP) ? PM_DATA : op_reg;
    wire [7:0] byte1_now = (state_reg == mcuifd_pkg::FETCH_B1) ? PM_DATA : b1_reg;
    wire [7:0] byte2_now = (state_reg == mcuifd_pkg::FETCH_B2) ? PM_DATA : mcuifd_pkg::BYTE_ZERO;

    mcuifd_opclass u_class (
        .opcode(op_now),
        .cls(cls)
    );

    wire last_byte = take && ((state_reg == mcuifd_pkg::FETCH_OP && cls.len == mcuifd_pkg::LEN_ONE)
        || (state_reg == mcuifd_pkg::FETCH_B1 && cls.len == mcuifd_pkg::LEN_TWO)
        || (state_reg == mcuifd_pkg::FETCH_B2));

    // counter stands on the last byte when the target forms, one more passes the whole instruction
    wire [15:0] pc_after = PM_ADDR + mcuifd_pkg::PC_STEP;
    wire [7:0] rel_byte = cls.rel2 ? byte2_now : byte1_now;
    wire [15:0] rel_target = pc_after + {{8{rel_byte[7]}}, rel_byte};
    wire [15:0] abs11_target = {pc_after[15:11], op_now[7:5], byte1_now};
    wire [15:0] abs16_target = {byte1_now, byte2_now};
    wire [15:0] target_next = cls.abs16 ? abs16_target
        : (cls.abs11 ? abs11_target : (cls.is_rel ? rel_target : pc_after));

    wire [4:0] reg_addr_next = (cls.opnd == mcuifd_pkg::OPND_REG) ? {BANK_SEL, op_now[2:0]}
        : ((cls.opnd == mcuifd_pkg::OPND_IND) ? {BANK_SEL, 2'b00, op_now[0]} : 5'h00);

    wire [3:0] xmove_next = cls.movx
        ? ({1'b0, EXTERNAL_ACCESS_TIMING_CONTROL} + mcuifd_pkg::XMOVE_BASE_CYCLES) : 4'h0;

    // opnd bytes of a one-byte instruction are forced to zero, its operand lives in the opcode
    wire [7:0] opnd1_next = (cls.len == mcuifd_pkg::LEN_ONE) ? mcuifd_pkg::BYTE_ZERO : byte1_now;
    wire [7:0] opnd2_next = byte2_now;

    ////////////////////////////////////////////////////////////////////////
    // fetch sequencer

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            mcuifd_pkg::FETCH_OP: begin
                if (take) begin
                    state_next = (cls.len == mcuifd_pkg::LEN_ONE) ? mcuifd_pkg::EXEC_WAIT : mcuifd_pkg::FETCH_B1;
                end
            end
            mcuifd_pkg::FETCH_B1: begin
                if (take) begin
                    state_next = (cls.len == mcuifd_pkg::LEN_TWO) ? mcuifd_pkg::EXEC_WAIT : mcuifd_pkg::FETCH_B2;
                end
            end
            mcuifd_pkg::FETCH_B2: begin
                if (take) begin
                    state_next = mcuifd_pkg::EXEC_WAIT;
                end
            end
            mcuifd_pkg::EXEC_WAIT: begin
                if (EXEC_DONE) begin
                    state_next = mcuifd_pkg::FETCH_OP;
                end
            end
        endcase
    end

    wire exec_end = (state_reg == mcuifd_pkg::EXEC_WAIT) && EXEC_DONE;
    // a load from the core outranks a taken branch: returns and table jumps
    wire [15:0] pc_next = take ? pc_after
        : (exec_end && EXEC_LOAD ? EXEC_ADDR
        : (exec_end && EXEC_TAKE ? BRANCH_TARGET : PM_ADDR));

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_reg <= mcuifd_pkg::FETCH_OP;
            PM_ADDR <= mcuifd_pkg::PC_RESET;
            PM_RD <= 1'b1;
            INSN_VALID <= 1'b0;
            op_reg <= mcuifd_pkg::BYTE_ZERO;
            b1_reg <= mcuifd_pkg::BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            PM_ADDR <= pc_next;
            PM_RD <= (state_next != mcuifd_pkg::EXEC_WAIT);
            INSN_VALID <= last_byte;
            if (take && state_reg == mcuifd_pkg::FETCH_OP) begin
                op_reg <= PM_DATA;
            end
            if (take && state_reg == mcuifd_pkg::FETCH_B1) begin
                b1_reg <= PM_DATA;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            INSN <= '0;
            OPND_KIND <= mcuifd_pkg::OPND_NONE;
            REG_ADDR <= 5'h00;
            DIRECT_ADDR <= mcuifd_pkg::BYTE_ZERO;
            DIRECT_SFR <= 1'b0;
            BRANCH_TARGET <= mcuifd_pkg::PC_RESET;
            FLAG_MASK <= 4'h0;
            XMOVE_CYCLES <= 4'h0;
        end else if (last_byte) begin
            INSN <= '{opcode: op_now, opnd1: opnd1_next, opnd2: opnd2_next, len: cls.len};
            OPND_KIND <= cls.opnd;
            REG_ADDR <= reg_addr_next;
            DIRECT_ADDR <= cls.has_direct ? byte1_now : mcuifd_pkg::BYTE_ZERO;
            DIRECT_SFR <= cls.has_direct && (byte1_now >= mcuifd_pkg::SFR_BASE);
            BRANCH_TARGET <= target_next;
            FLAG_MASK <= cls.flags;
            XMOVE_CYCLES <= xmove_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_single_fetch;
        take && state_reg == mcuifd_pkg::FETCH_OP && cls.len == mcuifd_pkg::LEN_ONE;
    endsequence
    sequence s_double_fetch;
        take && state_reg == mcuifd_pkg::FETCH_OP && cls.len == mcuifd_pkg::LEN_TWO;
    endsequence
    sequence s_idle_wait;
        state_reg == mcuifd_pkg::EXEC_WAIT && !EXEC_DONE;
    endsequence
    sequence s_exec_load;
        exec_end && EXEC_LOAD;
    endsequence

    // byte framing of the stream
    a_single_byte_word: assert property (s_single_fetch
        |=> INSN_VALID && INSN.len == mcuifd_pkg::LEN_ONE && INSN.opcode == $past(PM_DATA))
        else $error("one-byte instruction not issued");
    a_insn_single_pulse: assert property (INSN_VALID
        |=> !INSN_VALID)
        else $error("instruction strobe longer than one cycle");
    a_single_no_operand: assert property (INSN_VALID && INSN.len == mcuifd_pkg::LEN_ONE
        |-> INSN.opnd1 == 8'h00 && INSN.opnd2 == 8'h00)
        else $error("one-byte instruction has operand");
    a_double_byte_order: assert property (s_double_fetch
        |=> state_reg == mcuifd_pkg::FETCH_B1 && PM_ADDR == $past(PM_ADDR) + 16'h0001)
        else $error("second byte not fetched next");
    a_double_last_byte: assert property (INSN_VALID && INSN.len == mcuifd_pkg::LEN_TWO
        |-> $past(state_reg) == mcuifd_pkg::FETCH_B1 && INSN.opnd2 == 8'h00)
        else $error("two-byte instruction length wrong");
    a_triple_byte_path: assert property (INSN_VALID && INSN.len == mcuifd_pkg::LEN_THREE
        |-> $past(state_reg) == mcuifd_pkg::FETCH_B2)
        else $error("three-byte instruction short");

    // operand forms, sampled on the strobe cycle
    a_direct_sfr_split: assert property (INSN_VALID && (INSN.opcode == 8'hE5 || INSN.opcode == 8'h95)
        |-> DIRECT_ADDR == INSN.opnd1 && DIRECT_SFR == INSN.opnd1[7])
        else $error("direct operand address wrong");
    a_rel_signed_add: assert property (INSN_VALID && INSN.opcode == 8'h80
        |-> BRANCH_TARGET == $past(PM_ADDR) + 16'h0001 + {{8{INSN.opnd1[7]}}, INSN.opnd1})
        else $error("relative target wrong");
    a_reg_bank_select: assert property (INSN_VALID && OPND_KIND == mcuifd_pkg::OPND_REG
        |-> REG_ADDR == {$past(BANK_SEL), INSN.opcode[2:0]})
        else $error("working register wrong");
    a_indirect_pointer: assert property (INSN_VALID && OPND_KIND == mcuifd_pkg::OPND_IND
        |-> REG_ADDR[2:1] == 2'b00 && REG_ADDR[0] == INSN.opcode[0])
        else $error("pointer not R0 or R1");
    a_xmove_timing: assert property (INSN_VALID && XMOVE_CYCLES != 4'h0
        |-> XMOVE_CYCLES == {1'b0, $past(EXTERNAL_ACCESS_TIMING_CONTROL)} + 4'h1)
        else $error("external move timing wrong");
    a_xmove_idle_zero: assert property (INSN_VALID && INSN.len != mcuifd_pkg::LEN_ONE
        |-> XMOVE_CYCLES == 4'h0)
        else $error("timing reported for a non-move");
    a_add_flag_mask: assert property (INSN_VALID && INSN.opcode == 8'h28
        |-> FLAG_MASK == 4'b1111)
        else $error("add flag effects wrong");
    a_mul_flag_bits: assert property (INSN_VALID && INSN.opcode == 8'hA4
        |-> FLAG_MASK[mcuifd_pkg::FLAG_P] && FLAG_MASK[mcuifd_pkg::FLAG_OV]
        && !FLAG_MASK[mcuifd_pkg::FLAG_AC] && FLAG_MASK[mcuifd_pkg::FLAG_CY])
        else $error("multiply flag effects wrong");

    // counter movement and the exec handshake
    a_pc_step_byte: assert property (take
        |=> PM_ADDR == $past(PM_ADDR) + 16'h0001)
        else $error("counter did not step");
    a_wait_no_fetch: assert property (state_reg == mcuifd_pkg::EXEC_WAIT
        |-> !PM_RD)
        else $error("fetch requested while waiting");
    a_wait_holds_counter: assert property (s_idle_wait
        |=> $stable(PM_ADDR))
        else $error("counter moved while waiting");
    a_branch_target_load: assert property (exec_end && EXEC_TAKE && !EXEC_LOAD
        |=> PM_ADDR == $past(BRANCH_TARGET))
        else $error("taken branch not applied");
    a_load_beats_take: assert property (s_exec_load
        |=> PM_ADDR == $past(EXEC_ADDR))
        else $error("loaded counter wrong");
    a_short_abs_target: assert property (INSN_VALID && INSN.opcode[3:0] == 4'h1
        |-> INSN.len == mcuifd_pkg::LEN_TWO && BRANCH_TARGET[10:0] == {INSN.opcode[7:5], INSN.opnd1})
        else $error("short target wrong");
    a_abs_replace: assert property (INSN_VALID && INSN.opcode == 8'h02
        |-> BRANCH_TARGET == {INSN.opnd1, INSN.opnd2})
        else $error("long target wrong");
endmodule

/* File: mcuifd_pmem.sv */
// program memory model answering instruction fetches
`timescale 1ns/1ps
module mcuifd_pmem (
    input wire logic clk, // core clock
    input wire logic [15:0] addr, // fetch address
    input wire logic rd, // fetch request
    input wire logic slow, // answer only every other cycle
    output logic [7:0] data, // byte at addr while valid
    output logic valid // byte offered this cycle
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_reg;
    logic stall_reg;
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'h00;
        end
        last_reg = 8'h00;
        stall_reg = 1'b0;
    end
    assign valid = rd & ~(slow & stall_reg);
    // idle bus shows the inverted last byte, so a late sample cannot match by luck
    assign data = valid ? mem[addr] : ~last_reg;
    always @(posedge clk) begin
        stall_reg <= slow ? ~stall_reg : 1'b0;
        if (valid) begin
            last_reg <= mem[addr];
        end
    end
endmodule

/* File: mcuifd_top_test.sv */
// self-checking bench for the instruction format decoder
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module mcuifd_top_test;
    logic clk, rst_n, pm_valid, pm_rd, insn_valid, direct_sfr, slow;
    logic exec_done, exec_take, exec_load;
    logic [7:0] pm_data, direct_addr;
    logic [1:0] bank_sel;
    logic [2:0] xfield;
    logic [15:0] exec_addr, pm_addr, branch_target;
    logic [4:0] reg_addr;
    logic [3:0] flag_mask, xmove_cycles;
    mcuifd_pkg::mcuifd_insn_t insn;
    mcuifd_pkg::mcuifd_opnd_t opnd_kind;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    mcuifd_top dut (.CLK(clk), .RST_N(rst_n), .PM_DATA(pm_data), .PM_VALID(pm_valid), .BANK_SEL(bank_sel),
        .EXTERNAL_ACCESS_TIMING_CONTROL(xfield), .EXEC_DONE(exec_done), .EXEC_TAKE(exec_take),
        .EXEC_LOAD(exec_load), .EXEC_ADDR(exec_addr), .PM_ADDR(pm_addr), .PM_RD(pm_rd),
        .INSN_VALID(insn_valid), .INSN(insn), .OPND_KIND(opnd_kind), .REG_ADDR(reg_addr),
        .DIRECT_ADDR(direct_addr), .DIRECT_SFR(direct_sfr), .BRANCH_TARGET(branch_target),
        .FLAG_MASK(flag_mask), .XMOVE_CYCLES(xmove_cycles));
    mcuifd_pmem mem (.clk(clk), .addr(pm_addr), .rd(pm_rd), .slow(slow), .data(pm_data), .valid(pm_valid));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // every test together needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end

    task wait_valid;
        repeat (40) if (insn_valid !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        `CHK(insn_valid, 1'b1)
    endtask

    // exec handshake is honoured only once the fetch has ended
    task issue(input logic ld, input logic tk, input logic [15:0] a, input logic [15:0] exp);
        repeat (40) if (pm_rd !== 1'b0) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        exec_done <= 1'b1;
        exec_load <= ld;
        exec_take <= tk;
        exec_addr <= a;
        @(posedge clk);
        exec_done <= 1'b0;
        #1;
        `CHK(pm_rd, 1'b1)
        `CHK(pm_addr, exp)
    endtask

    task fetch(input logic [15:0] at, input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        mem.mem[at] = b0;
        mem.mem[at + 16'h0001] = b1;
        mem.mem[at + 16'h0002] = b2;
        issue(1'b1, 1'b0, at, at);
        wait_valid();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_long;
        wait_valid();
        `CHK(insn, {8'h02, 8'h12, 8'h34, 2'h3})
        `CHK(pm_addr, 16'h0003)
        `CHK(branch_target, 16'h1234)
        issue(1'b0, 1'b1, 16'h0000, 16'h1234);
        $display("test long done");
    endtask

    task t_reg;
        @(posedge clk) bank_sel <= 2'h2;
        fetch(16'h0100, 8'hED, 8'h5A, 8'h5A);
        `CHK(insn, {8'hED, 16'h0000, 2'h1})
        `CHK(opnd_kind, mcuifd_pkg::OPND_REG)
        `CHK(reg_addr, 5'h15)
        `CHK(flag_mask, 4'h8)
        `CHK(xmove_cycles, 4'h0)
        @(posedge clk) bank_sel <= 2'h0;
        fetch(16'h0110, 8'h28, 8'hA5, 8'hA5);
        `CHK(reg_addr, 5'h00)
        `CHK(flag_mask, 4'hF)
        fetch(16'h0120, 8'hA4, 8'h5A, 8'h5A);
        `CHK(insn, {8'hA4, 16'h0000, 2'h1})
        `CHK(flag_mask, 4'hD)
        $display("test reg done");
    endtask

    task t_ind;
        @(posedge clk) slow <= 1'b1;
        bank_sel <= 2'h1;
        fetch(16'h0200, 8'hE7, 8'h33, 8'h33);
        `CHK(opnd_kind, mcuifd_pkg::OPND_IND)
        `CHK(reg_addr, 5'h09)
        `CHK(pm_addr, 16'h0201)
        @(posedge clk) bank_sel <= 2'h3;
        fetch(16'h0210, 8'hE6, 8'h33, 8'h33);
        `CHK(reg_addr, 5'h18)
        @(posedge clk) slow <= 1'b0;
        $display("test indirect done");
    endtask

    task t_direct;
        fetch(16'h0300, 8'hE5, 8'h90, 8'h5A);
        `CHK(insn, {8'hE5, 8'h90, 8'h00, 2'h2})
        `CHK(direct_addr, 8'h90)
        `CHK(direct_sfr, 1'b1)
        `CHK(opnd_kind, mcuifd_pkg::OPND_NONE)
        `CHK(pm_addr, 16'h0302)
        fetch(16'h0320, 8'h95, 8'h80, 8'h5A);
        `CHK(insn, {8'h95, 8'h80, 8'h00, 2'h2})
        `CHK(direct_addr, 8'h80)
        `CHK(direct_sfr, 1'b1)
        `CHK(flag_mask, 4'hF)
        fetch(16'h0310, 8'hE5, 8'h7F, 8'h5A);
        `CHK(direct_addr, 8'h7F)
        `CHK(direct_sfr, 1'b0)
        $display("test direct done");
    endtask

    task t_rel;
        fetch(16'h0400, 8'h80, 8'hFE, 8'h11);
        `CHK(branch_target, 16'h0400)
        fetch(16'h0410, 8'h80, 8'h7F, 8'h11);
        `CHK(branch_target, 16'h0491)
        fetch(16'h0500, 8'hB4, 8'h55, 8'h80);
        `CHK(branch_target, 16'h0483)
        issue(1'b0, 1'b1, 16'h0000, 16'h0483);
        $display("test relative done");
    endtask

    task t_abs;
        fetch(16'h0FFE, 8'hE1, 8'h34, 8'h00);
        `CHK(branch_target, 16'h1734)
        `CHK(pm_addr, 16'h1000)
        fetch(16'h0800, 8'hF1, 8'h56, 8'h00);
        `CHK(insn, {8'hF1, 8'h56, 8'h00, 2'h2})
        `CHK(branch_target, 16'h0F56)
        `CHK(pm_addr, 16'h0802)
        issue(1'b1, 1'b1, 16'h0700, 16'h0700);
        issue(1'b0, 1'b0, 16'h0123, 16'h0701);
        $display("test absolute done");
    endtask

    task t_movx;
        logic [7:0] op;
        for (int f = 0; f < 8; f++) begin
            op = f[0] ? 8'hF2 : 8'hE0;
            @(posedge clk) xfield <= f[2:0];
            fetch(16'h0600, op, 8'h44, 8'h44);
            `CHK(xmove_cycles, {1'b0, f[2:0]} + 4'h1)
            `CHK(insn, {op, 16'h0000, 2'h1})
        end
        $display("test external move done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        slow = 1'b0;
        bank_sel = 2'h0;
        xfield = 3'h0;
        exec_done = 1'b0;
        exec_take = 1'b0;
        exec_load = 1'b0;
        exec_addr = 16'h0000;
        #1;
        mem.mem[0] = 8'h02;
        mem.mem[1] = 8'h12;
        mem.mem[2] = 8'h34;
        repeat (8) @(posedge clk);
        #1;
        `CHK(pm_addr, 16'h0000)
        `CHK(insn_valid, 1'b0)
        @(posedge clk) rst_n <= 1'b1;
        t_long();
        t_reg();
        t_ind();
        t_direct();
        t_rel();
        t_abs();
        t_movx();
        end_sim();
    end
endmodule
